//--- verilog/fsp_pkg.sv
/*
 * Constants, types and the register map of the flash self-programming
 * controller. Assumes a 100 MHz system clock and a 4096-word program
 * flash in 128 pages of 32 words.
 */
`default_nettype none
package fsp_pkg;
    // ------------------------------------------------------------------
    // Register map (byte offsets on the AHB-Lite slave)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PTR_LO = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PTR_HI = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DATA_LO = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_DATA_HI = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STORE = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_LOAD = 8'h18;

    // ------------------------------------------------------------------
    // Control/status field layout and command codes
    // ------------------------------------------------------------------
    localparam int BIT_EN = 0;
    localparam int CMD_LSB = 1;
    localparam int CMD_MSB = 4;
    localparam int BIT_REEN = 4;
    localparam int BIT_BUSY = 6;
    localparam int BIT_IE = 7;
    localparam logic [3:0] CMD_LOAD = 4'h0;
    localparam logic [3:0] CMD_ERASE = 4'h1;
    localparam logic [3:0] CMD_WRITE = 4'h2;
    localparam logic [3:0] CMD_LOCK = 4'h4;
    localparam logic [3:0] CMD_REEN = 4'h8;
    localparam logic [2:0] WIN_CYC = 3'h4;

    // ------------------------------------------------------------------
    // Pointer fields, buffer and lock bits
    // ------------------------------------------------------------------
    localparam int PTR_W = 16;
    localparam int WORD_LSB = 1;
    localparam int WORD_W = 5;
    localparam int PAGE_LSB = 6;
    localparam int PAGE_W = 7;
    localparam int BUF_DEPTH = 32;
    localparam logic [PAGE_W-1:0] HALT_ON_WRITE_SECTION_FIRST_PAGE = 7'h7c;
    localparam logic [15:0] BUF_ERASED = 16'hffff;
    localparam int LOCK_LSB = 2;
    localparam int LOCK_W = 4;
    localparam logic [LOCK_W-1:0] LOCK_RST = 4'hf;
    localparam logic [1:0] LOCK_PAD = 2'h3;
    localparam logic [PTR_W-1:0] LOCK_ADDR = 16'h0001;
    localparam logic [7:0] BYTE_BLOCKED = 8'hff;
    localparam logic [15:0] APP_RESET_VEC = 16'h0000;
    localparam logic [15:0] BOOT_RESET_VEC = 16'h0f80;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam real SPM_MIN_MS = 3.7;
    localparam real SPM_MAX_MS = 4.5;
    localparam real CLK_KHZ = 100000.0;
    localparam int SPM_MIN_CYC = int'(SPM_MIN_MS * CLK_KHZ);
    localparam int SPM_MAX_CYC = int'(SPM_MAX_MS * CLK_KHZ);
    localparam int CNT_W = 20;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE, OP_LOCK} fsp_op_e;
    typedef struct packed {
        logic go;
        logic erase;
        logic write;
        logic [PAGE_W-1:0] page;
    } fsp_flash_cmd_s;
endpackage
`default_nettype wire

//--- verilog/fsp_ctrl.sv
/*
 * Flash self-programming controller: command window, page buffer,
 * erase/write/lock sequencing, busy flag, CPU halt and reset vector.
 * Assumes an AHB-Lite master, a flash array that acts on flashCmd.go
 * and reads the buffer through bufIdx, and asynchronous fuse and
 * EEPROM-busy pins.
 */
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
// Operation
// - Reset vector is 0x0000 when boot fuse reads 1, boot start when 0.
// - CPU has no path to change any fuse.
// - Pointer splits into word-in-page low field and page high field.
// - Page address latched at operation start; pointer then free.
// - Lock-bit programming ignores the pointer entirely.
// - Program-memory load uses pointer bit 0 as byte select.
// - Erase code plus store within four cycles erases the pointed page.
// - Erase or write to halt-on-write section halts the CPU.
// - Load code plus store writes R1:R0 into buffer word slot.
// - Buffer cleared after page write, on re-enable write, on reset.
// - EEPROM write during buffer loading discards loaded data.
// - Write code plus store programs the buffer into the page.
// - Interrupt asserted while enabled and enable bit is clear.
// - Page erase or write blocks section reads; busy flag set.
// - Busy flag stays until software issues the re-enable command.
// - Lock code plus store programs lock bits where R0 bits are zero.
// - Lock programming neither halts the CPU nor blocks reads.
// - EEPROM write blocks self-programming and lock-bit reads.
// - Buffer loads accepted before erase or between erase and write.
// - Command and enable bits clear if no store within four cycles.
// - Programmed lock bits read as zero, unprogrammed as one.
// - Each erase, write or lock operation lasts 3.7 to 4.5 ms.
`timescale 1ns/100ps
`default_nettype none
module fsp_ctrl #(
    parameter int PROG_CYCLES = fsp_pkg::SPM_MIN_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic bootFusePin,
    input wire logic eeWriteActivePin,
    output logic [15:0] resetVector,
    output logic cpuHalt,
    output logic rwwBusy,
    output logic spmIrq,
    output fsp_pkg::fsp_flash_cmd_s flashCmd,
    input wire logic [fsp_pkg::WORD_W-1:0] bufIdx,
    output logic [15:0] bufWord,
    output logic [fsp_pkg::PTR_W-1:0] flashRdAddr,
    input wire logic [7:0] flashRdByte
);
    import fsp_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] pinMeta_q;
    logic [1:0] pinSync_q;
    logic eePrev_q;
    logic eeActive;
    logic bootFuse;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
            eePrev_q <= 1'b0;
        end else begin
            pinMeta_q <= {bootFusePin, eeWriteActivePin};
            pinSync_q <= pinMeta_q;
            eePrev_q <= pinSync_q[0];
        end
    end
    assign eeActive = pinSync_q[0];
    assign bootFuse = pinSync_q[1];

    // ------------------------------------------------------------------
    // AHB-Lite slave phases
    // ------------------------------------------------------------------
    logic wrPend_q, wrPend_d;
    logic rdPend_q, rdPend_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic accept;

    // Reads take one wait state so read data always leaves a flop
    assign accept = hsel && htrans[1] && hready;
    assign hreadyout = !rdPend_q;
    assign hresp = 1'b0;

    always_comb begin
        wrPend_d = 1'b0;
        rdPend_d = 1'b0;
        addr_d = addr_q;
        if (accept) begin
            wrPend_d = hwrite;
            rdPend_d = !hwrite;
            addr_d = haddr[ADDR_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q <= '0;
        end else begin
            wrPend_q <= wrPend_d;
            rdPend_q <= rdPend_d;
            addr_q <= addr_d;
        end
    end

    // ------------------------------------------------------------------
    // Programming state
    // ------------------------------------------------------------------
    logic ctrlEn_q, ctrlEn_d;
    logic [3:0] cmd_q, cmd_d;
    logic ie_q, ie_d;
    logic [2:0] win_q, win_d;
    logic [7:0] ptrLo_q, ptrLo_d;
    logic [7:0] ptrHi_q, ptrHi_d;
    logic [7:0] dLo_q, dLo_d;
    logic [7:0] dHi_q, dHi_d;
    logic [15:0] buf_q [BUF_DEPTH];
    logic [15:0] buf_d [BUF_DEPTH];
    logic busy_q, busy_d;
    logic halt_q, halt_d;
    fsp_op_e op_q, op_d;
    logic [CNT_W-1:0] opCnt_q, opCnt_d;
    logic [LOCK_W-1:0] lockPend_q, lockPend_d;
    logic [LOCK_W-1:0] lockBits_q, lockBits_d;
    fsp_flash_cmd_s flash_q, flash_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic [15:0] resetVec_q, resetVec_d;
    logic [PTR_W-1:0] ptr;
    logic [PAGE_W-1:0] ptrPage;
    logic [WORD_W-1:0] ptrWord;
    logic wrEn, storeHit, opDone, clearBuf, lockRd, idle;

    function automatic logic inNrww(input logic [PAGE_W-1:0] page);
        return page >= HALT_ON_WRITE_SECTION_FIRST_PAGE;
    endfunction

    assign ptr = {ptrHi_q, ptrLo_q};
    assign ptrPage = ptr[PAGE_LSB +: PAGE_W];
    assign ptrWord = ptr[WORD_LSB +: WORD_W];
    assign idle = (op_q == OP_IDLE);
    assign wrEn = wrPend_q;
    // No store is taken while EEPROM is writing
    assign storeHit = wrEn && addr_q == OFF_STORE && ctrlEn_q &&
                      win_q != '0 && idle && !eeActive;
    assign opDone = !idle && opCnt_q == CNT_W'(PROG_CYCLES - 1);
    assign lockRd = ctrlEn_q && cmd_q == CMD_LOCK && win_q != '0 &&
                    !eeActive && ptr == LOCK_ADDR;

    always_comb begin
        ctrlEn_d = ctrlEn_q;
        cmd_d = cmd_q;
        ie_d = ie_q;
        win_d = win_q;
        ptrLo_d = ptrLo_q;
        ptrHi_d = ptrHi_q;
        dLo_d = dLo_q;
        dHi_d = dHi_q;
        buf_d = buf_q;
        busy_d = busy_q;
        halt_d = halt_q;
        op_d = op_q;
        opCnt_d = opCnt_q;
        lockPend_d = lockPend_q;
        lockBits_d = lockBits_q;
        flash_d = flash_q;
        flash_d.go = 1'b0;
        hrdata_d = hrdata_q;
        clearBuf = 1'b0;
        resetVec_d = bootFuse ? APP_RESET_VEC : BOOT_RESET_VEC;

        // Timed command window
        if (ctrlEn_q && idle && win_q != '0) begin
            win_d = win_q - 1'b1;
            if (win_q == 3'h1) begin
                ctrlEn_d = 1'b0;
                cmd_d = CMD_LOAD;
            end
        end

        // Running operation
        if (!idle) begin
            opCnt_d = opCnt_q + 1'b1;
            if (opDone) begin
                op_d = OP_IDLE;
                opCnt_d = '0;
                ctrlEn_d = 1'b0;
                cmd_d = CMD_LOAD;
                halt_d = 1'b0;
                if (op_q == OP_WRITE) clearBuf = 1'b1;
                // Programming only ever drives lock bits to zero
                if (op_q == OP_LOCK) lockBits_d = lockBits_q & lockPend_q;
            end
        end

        // EEPROM write start throws away a partly loaded page
        if (pinSync_q[0] && !eePrev_q && idle) clearBuf = 1'b1;

        // Register writes; fuses have no write path at all
        if (wrEn) begin
            case (addr_q)
                OFF_CTRL: begin
                    ie_d = hwdata[BIT_IE];
                    if (idle && !eeActive) begin
                        ctrlEn_d = hwdata[BIT_EN];
                        cmd_d = hwdata[CMD_MSB:CMD_LSB];
                        win_d = hwdata[BIT_EN] ? WIN_CYC : '0;
                        if (hwdata[BIT_REEN]) clearBuf = 1'b1;
                    end
                end
                OFF_PTR_LO: ptrLo_d = hwdata[7:0];
                OFF_PTR_HI: ptrHi_d = hwdata[7:0];
                OFF_DATA_LO: dLo_d = hwdata[7:0];
                OFF_DATA_HI: dHi_d = hwdata[7:0];
                default: ;
            endcase
        end

        // Store instruction
        if (storeHit) begin
            win_d = '0;
            case (cmd_q)
                CMD_ERASE, CMD_WRITE: begin
                    op_d = (cmd_q == CMD_ERASE) ? OP_ERASE : OP_WRITE;
                    flash_d.go = 1'b1;
                    flash_d.erase = (cmd_q == CMD_ERASE);
                    flash_d.write = (cmd_q == CMD_WRITE);
                    flash_d.page = ptrPage;
                    busy_d = 1'b1;
                    halt_d = inNrww(ptrPage);
                    opCnt_d = '0;
                end
                CMD_LOCK: begin
                    // Pointer plays no part; no halt, no busy flag
                    op_d = OP_LOCK;
                    lockPend_d = dLo_q[LOCK_LSB +: LOCK_W];
                    opCnt_d = '0;
                end
                CMD_LOAD: begin
                    // Accepted in any erase state of the page
                    buf_d[ptrWord] = {dHi_q, dLo_q};
                    ctrlEn_d = 1'b0;
                end
                CMD_REEN: begin
                    busy_d = 1'b0;
                    ctrlEn_d = 1'b0;
                    cmd_d = CMD_LOAD;
                end
                default: begin
                    ctrlEn_d = 1'b0;
                    cmd_d = CMD_LOAD;
                end
            endcase
        end

        if (clearBuf) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_d[i] = BUF_ERASED;
            end
        end

        // Read data, captured in the wait state
        if (rdPend_q) begin
            case (addr_q)
                OFF_CTRL: hrdata_d = 32'({ie_q, busy_q, 1'b0, cmd_q,
                                          ctrlEn_q});
                OFF_PTR_LO: hrdata_d = 32'(ptrLo_q);
                OFF_PTR_HI: hrdata_d = 32'(ptrHi_q);
                OFF_DATA_LO: hrdata_d = 32'(dLo_q);
                OFF_DATA_HI: hrdata_d = 32'(dHi_q);
                OFF_LOAD: begin
                    if (lockRd) begin
                        hrdata_d = 32'({LOCK_PAD, lockBits_q, LOCK_PAD});
                        ctrlEn_d = 1'b0;
                        cmd_d = CMD_LOAD;
                        win_d = '0;
                    end else if (busy_q && !inNrww(ptrPage)) begin
                        hrdata_d = 32'(BYTE_BLOCKED);
                    end else begin
                        hrdata_d = 32'(flashRdByte);
                    end
                end
                default: hrdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlEn_q <= 1'b0;
            cmd_q <= CMD_LOAD;
            ie_q <= 1'b0;
            win_q <= '0;
            ptrLo_q <= '0;
            ptrHi_q <= '0;
            dLo_q <= '0;
            dHi_q <= '0;
            for (int i = 0; i < BUF_DEPTH; i++) buf_q[i] <= BUF_ERASED;
            busy_q <= 1'b0;
            halt_q <= 1'b0;
            op_q <= OP_IDLE;
            opCnt_q <= '0;
            lockPend_q <= LOCK_RST;
            lockBits_q <= LOCK_RST;
            flash_q <= '0;
            hrdata_q <= '0;
            resetVec_q <= APP_RESET_VEC;
        end else begin
            ctrlEn_q <= ctrlEn_d;
            cmd_q <= cmd_d;
            ie_q <= ie_d;
            win_q <= win_d;
            ptrLo_q <= ptrLo_d;
            ptrHi_q <= ptrHi_d;
            dLo_q <= dLo_d;
            dHi_q <= dHi_d;
            buf_q <= buf_d;
            busy_q <= busy_d;
            halt_q <= halt_d;
            op_q <= op_d;
            opCnt_q <= opCnt_d;
            lockPend_q <= lockPend_d;
            lockBits_q <= lockBits_d;
            flash_q <= flash_d;
            hrdata_q <= hrdata_d;
            resetVec_q <= resetVec_d;
        end
    end

    assign hrdata = hrdata_q;
    assign resetVector = resetVec_q;
    assign cpuHalt = halt_q;
    assign rwwBusy = busy_q;
    assign spmIrq = ie_q && !ctrlEn_q;
    assign flashCmd = flash_q;
    assign bufWord = buf_q[bufIdx];
    assign flashRdAddr = ptr;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] elapsed_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) elapsed_q <= '0;
        else if (idle) elapsed_q <= '0;
        else elapsed_q <= elapsed_q + 1'b1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    op_length_a: assert property ($fell(!idle) |->
        elapsed_q == CNT_W'(PROG_CYCLES))
        else $error("operation length wrong");
    en_held_a: assert property (!idle |-> ctrlEn_q)
        else $error("enable dropped during operation");
    window_expiry_a: assert property ((ctrlEn_q && idle && win_q == 3'h1 &&
        !storeHit && !wrEn && !(rdPend_q && addr_q == OFF_LOAD))
        |=> !ctrlEn_q && cmd_q == CMD_LOAD)
        else $error("window did not expire");
    busy_set_a: assert property ((storeHit && (cmd_q == CMD_ERASE ||
        cmd_q == CMD_WRITE)) |=> busy_q && flash_q.go ##1 !flash_q.go)
        else $error("busy flag or go pulse missing");
    lock_no_halt_a: assert property (op_q == OP_LOCK |-> !halt_q)
        else $error("cpu halted during lock programming");
    page_latched_a: assert property ((!idle && !$rose(!idle)) |->
        $stable(flash_q.page))
        else $error("latched page changed");
    ee_block_a: assert property ((eeActive && wrEn && addr_q == OFF_CTRL
        && !ctrlEn_q) |=> !ctrlEn_q)
        else $error("enable set during eeprom write");
    irq_level_a: assert property (($fell(!idle) && ie_q) |-> spmIrq)
        else $error("interrupt not raised");
    buf_clear_a: assert property ((opDone && op_q == OP_WRITE) |=>
        buf_q[0] == BUF_ERASED && buf_q[BUF_DEPTH-1] == BUF_ERASED)
        else $error("buffer not cleared after write");
    halt_halt_on_write_section_a: assert property ($rose(!idle) && op_q != OP_LOCK |->
        halt_q == inNrww(flash_q.page))
        else $error("halt does not match target section");
endmodule // fsp_ctrl
`default_nettype wire

//--- testbench/fsp_flash_model.sv
/*
 * Behavioural program flash array on the far side of the controller.
 * Assumes flashCmd.page holds through an operation and the buffer
 * stays readable until the copy of all 32 slots is over.
 */
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire fsp_pkg::fsp_flash_cmd_s flashCmd,
    input wire logic [15:0] bufWord,
    input wire logic [fsp_pkg::PTR_W-1:0] flashRdAddr,
    input wire logic [fsp_pkg::WORD_W-1:0] peekIdx,
    output logic [fsp_pkg::WORD_W-1:0] bufIdx,
    output logic [7:0] flashRdByte
);
    import fsp_pkg::*;
    // ------------------------------------------------------------------
    // Array, one slot copied per cycle
    // ------------------------------------------------------------------
    logic [7:0] mem [0:8191];
    logic [5:0] cnt;
    logic [6:0] pg;
    assign bufIdx = cnt[5] ? peekIdx : cnt[4:0];
    assign flashRdByte = mem[flashRdAddr[12:0]];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 6'h20;
            // Known pattern so untouched pages can be told apart
            for (int i = 0; i < 8192; i++) mem[i] <= 8'(i) ^ 8'h5a;
        end else if (flashCmd.go) begin
            pg <= flashCmd.page;
            if (flashCmd.write) cnt <= 6'h00;
            if (flashCmd.erase) begin
                for (int j = 0; j < 64; j++) begin
                    mem[{flashCmd.page, 6'(j)}] <= 8'hff;
                end
            end
        end else if (!cnt[5]) begin
            mem[{pg, cnt[4:0], 1'b0}] <= bufWord[7:0];
            mem[{pg, cnt[4:0], 1'b1}] <= bufWord[15:8];
            cnt <= cnt + 6'h01;
        end
    end
endmodule // fsp_flash_model
`default_nettype wire

//--- testbench/tb.sv
/*
 * Self-checking bench for the flash self-programming controller.
 * Assumes the AHB-Lite slave answers as handed over and a flash model
 * that copies the page buffer in 32 cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import fsp_pkg::*;
    logic clk, rst_n, hsel, hwrite, bootFusePin, eeWriteActivePin;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, cpuHalt, rwwBusy, spmIrq;
    logic [15:0] resetVector, bufWord, flashRdAddr;
    fsp_flash_cmd_s flashCmd;
    logic [WORD_W-1:0] bufIdx, peekIdx;
    logic [7:0] flashRdByte, v;
    int num_errors, comparisons;

    // Longer than the 32-cycle buffer copy
    fsp_ctrl #(.PROG_CYCLES(40)) uut (.clk(clk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .bootFusePin(bootFusePin), .eeWriteActivePin(eeWriteActivePin),
        .resetVector(resetVector), .cpuHalt(cpuHalt), .rwwBusy(rwwBusy),
        .spmIrq(spmIrq), .flashCmd(flashCmd), .bufIdx(bufIdx),
        .bufWord(bufWord), .flashRdAddr(flashRdAddr),
        .flashRdByte(flashRdByte));
    fsp_flash_model flash (.clk(clk), .rst_n(rst_n), .flashCmd(flashCmd),
        .bufWord(bufWord), .flashRdAddr(flashRdAddr), .peekIdx(peekIdx),
        .bufIdx(bufIdx), .flashRdByte(flashRdByte));

    // ------------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------------
    task automatic wait_rdy;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= 1'b1;
        wait_rdy;
        htrans <= 2'b00; hwdata <= {24'h0, d};
        wait_rdy;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= 1'b0;
        wait_rdy;
        htrans <= 2'b00;
        wait_rdy;
        d = hrdata[7:0];
    endtask
    task automatic chk(input string n, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, e, input string n);
        rd(a, v);
        chk(n, {8'h0, e}, {8'h0, v});
    endtask
    task automatic spm(input logic [7:0] c);
        wr(OFF_CTRL, c);
        wr(OFF_STORE, 8'h00);
    endtask
    task automatic set_ptr(input logic [15:0] p);
        wr(OFF_PTR_LO, p[7:0]);
        wr(OFF_PTR_HI, p[15:8]);
    endtask
    task automatic load(input logic [15:0] p, w);
        set_ptr(p);
        wr(OFF_DATA_LO, w[7:0]);
        wr(OFF_DATA_HI, w[15:8]);
        spm(8'h01);
    endtask
    task automatic wait_done;
        v = 8'h01;
        for (int i = 0; i < 100 && v[0] !== 1'b0; i++) rd(OFF_CTRL, v);
        chk("enable", 16'h0, 16'(v[0]));
        @(negedge clk);
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        num_errors++;
        tally_and_finish;
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; bootFusePin = 1'b1;
        eeWriteActivePin = 1'b0; peekIdx = 5'h03; num_errors = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("resetVector", APP_RESET_VEC, resetVector);
        rchk(OFF_CTRL, 8'h00, "ctrl");
        rchk(8'h1c, 8'h00, "unmapped");
        load(16'h0086, 16'h1234);
        @(negedge clk);
        chk("bufWord", 16'h1234, bufWord);
        @(posedge clk);
        eeWriteActivePin <= 1'b1;
        repeat (4) @(posedge clk);
        spm(8'h03);
        rchk(OFF_CTRL, 8'h00, "ctrl");
        chk("rwwBusy", 16'h0, 16'(rwwBusy));
        chk("bufWord", 16'hffff, bufWord);
        eeWriteActivePin <= 1'b0;
        repeat (4) @(posedge clk);
        wr(OFF_CTRL, 8'h80);
        @(negedge clk);
        chk("spmIrq", 16'h1, 16'(spmIrq));
        set_ptr(16'h0080);
        spm(8'h83);
        set_ptr(16'h1f00);
        @(negedge clk);
        chk("page", 16'h0002, 16'(flashCmd.page));
        chk("rwwBusy", 16'h1, 16'(rwwBusy));
        chk("cpuHalt", 16'h0, 16'(cpuHalt));
        chk("spmIrq", 16'h0, 16'(spmIrq));
        chk("erase", 16'h1, 16'(flashCmd.erase));
        rchk(OFF_PTR_HI, 8'h1f, "ptr high");
        set_ptr(16'h0080);
        rchk(OFF_LOAD, BYTE_BLOCKED, "load");
        wait_done;
        chk("spmIrq", 16'h1, 16'(spmIrq));
        chk("rwwBusy", 16'h1, 16'(rwwBusy));
        rchk(OFF_CTRL, 8'hc0, "ctrl");
        spm(8'h11);
        @(negedge clk);
        chk("rwwBusy", 16'h0, 16'(rwwBusy));
        load(16'h0086, 16'h1234);
        set_ptr(16'h0080);
        spm(8'h05);
        @(negedge clk);
        chk("write", 16'h1, 16'(flashCmd.write));
        chk("cpuHalt", 16'h0, 16'(cpuHalt));
        wait_done;
        chk("bufWord", 16'hffff, bufWord);
        spm(8'h11);
        set_ptr(16'h0086);
        rchk(OFF_LOAD, 8'h34, "low byte");
        set_ptr(16'h0087);
        rchk(OFF_LOAD, 8'h12, "high byte");
        set_ptr(16'h0088);
        rchk(OFF_LOAD, 8'hff, "erased byte");
        set_ptr(16'h0100);
        rchk(OFF_LOAD, 8'h5a, "other page");
        set_ptr(16'h1f00);
        spm(8'h03);
        @(negedge clk);
        chk("cpuHalt", 16'h1, 16'(cpuHalt));
        wait_done;
        chk("cpuHalt", 16'h0, 16'(cpuHalt));
        spm(8'h11);
        wr(OFF_CTRL, 8'h03);
        repeat (6) @(posedge clk);
        rchk(OFF_CTRL, 8'h00, "ctrl");
        chk("rwwBusy", 16'h0, 16'(rwwBusy));
        set_ptr(16'h1234);
        wr(OFF_DATA_LO, 8'hef);
        spm(8'h09);
        @(negedge clk);
        chk("cpuHalt", 16'h0, 16'(cpuHalt));
        chk("rwwBusy", 16'h0, 16'(rwwBusy));
        wait_done;
        set_ptr(LOCK_ADDR);
        wr(OFF_CTRL, 8'h09);
        rchk(OFF_LOAD, 8'hef, "lock bits");
        bootFusePin <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("resetVector", BOOT_RESET_VEC, resetVector);
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
